//--- hw/ssl_pkg.sv
// Shared constants for the synthesizer serial load and lock monitor.
package ssl_pkg;
	// Serial frame layout, sent first bit first, control bit last.
	localparam int REF_W = 14;
	localparam int MAIN_W = 10;
	localparam int SWAL_W = 7;
	localparam int FRAME_W = REF_W + MAIN_W + SWAL_W + 1;
	localparam int REF_MSB = FRAME_W - 1;
	localparam int REF_LSB = FRAME_W - REF_W;
	localparam int MAIN_MSB = REF_LSB - 1;
	localparam int MAIN_LSB = REF_LSB - MAIN_W;
	localparam int SWAL_MSB = MAIN_LSB - 1;
	localparam int SWAL_LSB = MAIN_LSB - SWAL_W;
	localparam int CTRL_BIT = 0;
	localparam logic CTRL_LATCH = 1'h1;
	// Select code A0 A1 A2 = 1 1 0, held as {bit2, bit1, bit0}.
	localparam logic [2:0] SELECT_MATCH = 3'h3;
	// Typical reference and comparison rates.
	localparam longint REF_FREQ_HZ = 12800000;
	localparam longint COMP_FREQ_HZ = 6250;
	localparam logic [REF_W-1:0] REF_DIV_RESET = REF_W'(REF_FREQ_HZ / COMP_FREQ_HZ);
	localparam logic [MAIN_W-1:0] MAIN_DIV_RESET = 10'h001;
	localparam logic [SWAL_W-1:0] SWAL_DIV_RESET = 7'h00;
	localparam int PRESCALE_NOMINAL = 128;
	// Positions of the pin inputs in the synchroniser vector.
	localparam int PIN_N = 8;
	localparam int PIN_SEL0 = 0;
	localparam int PIN_SEL1 = 1;
	localparam int PIN_SEL2 = 2;
	localparam int PIN_SCLK = 3;
	localparam int PIN_SDATA = 4;
	localparam int PIN_SEN = 5;
	localparam int PIN_LOCK = 6;
	localparam int PIN_KEY = 7;
	// Key line rests high, oscillator off; lock detect rests high.
	localparam logic [PIN_N-1:0] PIN_RESET = 8'hc0;
	localparam int REF_PIN = 0;
	localparam int PRE_PIN = 1;
endpackage : ssl_pkg

//--- hw/ssl_divider.sv
// Programmable divider that emits one pulse every divisor input ticks.
`timescale 1ns/1ps
module ssl_divider #(
	parameter int W = 14
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic [W-1:0] divisor,
	output logic pulse_reg
);
	logic [W-1:0] cnt_reg;

	// A divisor of zero is treated as one.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
			pulse_reg <= 1'b0;
		end else begin
			pulse_reg <= 1'b0;
			if (tick) begin
				if (cnt_reg <= W'(1)) begin
					cnt_reg <= divisor;
					pulse_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - W'(1);
				end
			end
		end
	end
endmodule : ssl_divider

//--- hw/ssl_top.sv
// Serial divider load, dual-modulus control and out-of-lock fault latch.
// How it works
// - Select code A0 A1 A2 equal to 1 1 0 opens the input gates.
// - Clock, data and enable pass only while the select code matches.
// - Reference, main and swallow divider values load serially.
// - Each rising serial clock shifts one data bit into the shift register.
// - Enable high copies the shift register into the divider latches.
// - Reference divider brings the reference down to the comparison rate.
// - Modulus control selects the alternate prescaler modulus for swallow counts.
// - Main divider turns prescaled feedback into the divided oscillator pulse.
// - A gated enable pulse drives the loop filter bypass.
// - The gated enable pulse clears the fault latch.
// - Lock detect low after clearing sets the latch and lights the indicator.
// - Fault flag low while a fault is latched and the oscillator is on, high otherwise.
// - Key line low turns on oscillator and fault indicator gating.
// - A final control bit of one is needed for the latch to happen.
`timescale 1ns/1ps
module ssl_top
	import ssl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic select_code_bit0,
	input wire logic select_code_bit1,
	input wire logic select_code_bit2,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic serial_enable,
	input wire logic lock_detect,
	input wire logic osc_key_line,
	input wire logic ref_in,
	input wire logic prescaler_in,
	output logic decoder_match_output_n_reg,
	output logic [REF_W-1:0] ref_div_reg,
	output logic [MAIN_W-1:0] main_div_reg,
	output logic [SWAL_W-1:0] swal_div_reg,
	output logic loop_bypass_reg,
	output logic fault_reg,
	output logic fault_led_reg,
	output logic fault_flag_reg,
	output logic osc_on_level_reg,
	output logic modulus_ctrl_reg,
	output logic fr_pulse_reg,
	output logic fv_pulse_reg
);
	logic [PIN_N-1:0] pins;
	logic [PIN_N-1:0] s1_reg;
	logic [PIN_N-1:0] s2_reg;
	logic [PIN_N-1:0] s3_reg;
	logic [PIN_N-1:0] filt_reg;
	logic [PIN_N-1:0] prev_reg;
	logic [1:0] fs1_reg;
	logic [1:0] fs2_reg;
	logic [1:0] fs3_reg;
	logic [1:0] ffilt_reg;
	logic [1:0] fprev_reg;
	logic [FRAME_W-1:0] shift_reg;
	logic [SWAL_W-1:0] swal_cnt_reg;
	logic armed_reg;
	logic match;
	logic sclk_rise;
	logic sen_rise;
	logic sen_level;
	logic osc_on;
	logic ref_tick;
	logic pre_tick;
	logic fr_pulse;
	logic fv_pulse;

	assign pins = {osc_key_line, lock_detect, serial_enable, serial_data, serial_clk,
		select_code_bit2, select_code_bit1, select_code_bit0};

	// Three-stage synchronisers; a level counts once stages two and three agree.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= PIN_RESET;
			s2_reg <= PIN_RESET;
			s3_reg <= PIN_RESET;
			prev_reg <= PIN_RESET;
			fs1_reg <= '0;
			fs2_reg <= '0;
			fs3_reg <= '0;
			fprev_reg <= '0;
		end else begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			prev_reg <= filt_reg;
			fs1_reg <= {prescaler_in, ref_in};
			fs2_reg <= fs1_reg;
			fs3_reg <= fs2_reg;
			fprev_reg <= ffilt_reg;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_filt
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					filt_reg[gi] <= PIN_RESET[gi];
				end else if (s2_reg[gi] == s3_reg[gi]) begin
					filt_reg[gi] <= s3_reg[gi];
				end
			end
		end
		for (gi = 0; gi < 2; gi++) begin : g_ffilt
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					ffilt_reg[gi] <= 1'b0;
				end else if (fs2_reg[gi] == fs3_reg[gi]) begin
					ffilt_reg[gi] <= fs3_reg[gi];
				end
			end
		end
	endgenerate

	assign match = ({filt_reg[PIN_SEL2], filt_reg[PIN_SEL1], filt_reg[PIN_SEL0]}
		== SELECT_MATCH);
	assign sclk_rise = match & filt_reg[PIN_SCLK] & ~prev_reg[PIN_SCLK];
	assign sen_rise = match & filt_reg[PIN_SEN] & ~prev_reg[PIN_SEN];
	assign sen_level = match & filt_reg[PIN_SEN];
	assign osc_on = ~filt_reg[PIN_KEY];
	assign ref_tick = ffilt_reg[REF_PIN] & ~fprev_reg[REF_PIN];
	assign pre_tick = ffilt_reg[PRE_PIN] & ~fprev_reg[PRE_PIN];

	// Decoder output is low while the select code matches.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			decoder_match_output_n_reg <= 1'b1;
		end else begin
			decoder_match_output_n_reg <= ~match;
		end
	end

	// Serial shift register, first bit ends up at the top.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			shift_reg <= '0;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[FRAME_W-2:0], filt_reg[PIN_SDATA]};
		end
	end

	// Divider latches take the frame on enable when the control bit is one.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ref_div_reg <= REF_DIV_RESET;
			main_div_reg <= MAIN_DIV_RESET;
			swal_div_reg <= SWAL_DIV_RESET;
		end else if (sen_rise && shift_reg[CTRL_BIT] == CTRL_LATCH) begin
			ref_div_reg <= shift_reg[REF_MSB:REF_LSB];
			main_div_reg <= shift_reg[MAIN_MSB:MAIN_LSB];
			swal_div_reg <= shift_reg[SWAL_MSB:SWAL_LSB];
		end
	end

	// Loop filter bypass follows the gated enable pulse.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			loop_bypass_reg <= 1'b0;
		end else begin
			loop_bypass_reg <= sen_level;
		end
	end

	// Fault latch; loss of lock wins over the clearing enable.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			armed_reg <= 1'b0;
			fault_reg <= 1'b0;
		end else begin
			if (sen_rise) begin
				armed_reg <= 1'b1;
			end
			if (armed_reg && !filt_reg[PIN_LOCK]) begin
				fault_reg <= 1'b1;
			end else if (sen_rise) begin
				fault_reg <= 1'b0;
			end
		end
	end

	// Indicator and flag are gated by the oscillator-on level.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			osc_on_level_reg <= 1'b0;
			fault_led_reg <= 1'b0;
			fault_flag_reg <= 1'b1;
		end else begin
			osc_on_level_reg <= osc_on;
			fault_led_reg <= fault_reg & osc_on;
			fault_flag_reg <= ~(fault_reg & osc_on);
		end
	end

	ssl_divider #(.W(REF_W)) u_ref_div (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick(ref_tick),
		.divisor(ref_div_reg),
		.pulse_reg(fr_pulse)
	);

	ssl_divider #(.W(MAIN_W)) u_main_div (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick(pre_tick),
		.divisor(main_div_reg),
		.pulse_reg(fv_pulse)
	);

	// Swallow counter holds the alternate modulus for the first counts of a cycle.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			swal_cnt_reg <= '0;
			modulus_ctrl_reg <= 1'b0;
		end else if (fv_pulse) begin
			swal_cnt_reg <= swal_div_reg;
			modulus_ctrl_reg <= (swal_div_reg != '0);
		end else if (pre_tick && modulus_ctrl_reg) begin
			swal_cnt_reg <= swal_cnt_reg - SWAL_W'(1);
			if (swal_cnt_reg <= SWAL_W'(1)) begin
				modulus_ctrl_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fr_pulse_reg <= 1'b0;
			fv_pulse_reg <= 1'b0;
		end else begin
			fr_pulse_reg <= fr_pulse;
			fv_pulse_reg <= fv_pulse;
		end
	end

	a_select_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
		!match |=> $stable(shift_reg)) else $error("shift moved while unselected");
	a_shift_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
		sclk_rise |=> shift_reg[0] == $past(filt_reg[PIN_SDATA])) else $error("bad shift");
	a_latch_load: assert property (@(posedge sys_clk) disable iff (!rstn)
		sen_rise && shift_reg[CTRL_BIT] |=> ref_div_reg == $past(shift_reg[REF_MSB:REF_LSB])
		&& swal_div_reg == $past(shift_reg[SWAL_MSB:SWAL_LSB])) else $error("no latch");
	a_ctrl_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		sen_rise && !shift_reg[CTRL_BIT] |=> $stable(main_div_reg)) else $error("bad latch");
	a_bypass_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
		sen_rise |=> loop_bypass_reg) else $error("bypass missing");
	a_fault_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		sen_rise && filt_reg[PIN_LOCK] |=> !fault_reg) else $error("fault not cleared");
	a_fault_set: assert property (@(posedge sys_clk) disable iff (!rstn)
		armed_reg && !filt_reg[PIN_LOCK] |=> fault_reg
		##1 (fault_reg || $past(sen_rise && filt_reg[PIN_LOCK]))) else $error("fault not held");
	a_flag_low: assert property (@(posedge sys_clk) disable iff (!rstn)
		fault_reg && osc_on |=> !fault_flag_reg && fault_led_reg) else $error("flag high");
	a_led_inhibit: assert property (@(posedge sys_clk) disable iff (!rstn)
		!osc_on |=> !fault_led_reg && fault_flag_reg) else $error("led not inhibited");
	a_modulus_start: assert property (@(posedge sys_clk) disable iff (!rstn)
		fv_pulse && swal_div_reg != '0 |=> modulus_ctrl_reg) else $error("no modulus");
endmodule : ssl_top

//--- verif/ssl_ctrl_model.sv
// Station controller model driving the select code, serial load and key lines.
`timescale 1ns/1ps
module ssl_ctrl_model (
	input wire logic sys_clk,
	output logic select_code_bit0,
	output logic select_code_bit1,
	output logic select_code_bit2,
	output logic serial_clk,
	output logic serial_data,
	output logic serial_enable,
	output logic osc_key_line
);
	initial begin
		{select_code_bit2, select_code_bit1, select_code_bit0} = 3'h0;
		serial_clk = 1'h0;
		serial_data = 1'h0;
		serial_enable = 1'h0;
		osc_key_line = 1'h1;
	end

	task automatic set_key(input logic level);
		@(posedge sys_clk);
		osc_key_line <= level;
	endtask : set_key

	task automatic load(input logic [2:0] sel, input logic [31:0] frame);
		@(posedge sys_clk);
		{select_code_bit2, select_code_bit1, select_code_bit0} <= sel;
		repeat (6) @(posedge sys_clk);
		for (int i = 31; i >= 0; i--) begin
			serial_data <= frame[i];
			repeat (2) @(posedge sys_clk);
			serial_clk <= 1'h1;
			repeat (5) @(posedge sys_clk);
			serial_clk <= 1'h0;
			repeat (5) @(posedge sys_clk);
		end
		serial_data <= ~frame[0];
		serial_enable <= 1'h1;
		repeat (8) @(posedge sys_clk);
		serial_enable <= 1'h0;
		repeat (6) @(posedge sys_clk);
		{select_code_bit2, select_code_bit1, select_code_bit0} <= 3'h0;
		repeat (6) @(posedge sys_clk);
	endtask : load
endmodule : ssl_ctrl_model

//--- verif/ssl_top_tb.sv
// Self-checking testbench for the serial load and lock monitor.
`timescale 1ns/1ps
module ssl_top_tb;
	import ssl_pkg::*;
	logic sys_clk = 1'h0;
	logic rstn = 1'h0;
	logic lock_detect = 1'h1;
	logic s0, s1, s2, sclk, sdat, sen, key;
	logic match_n, bypass, fault, led, flag, osc_on;
	logic fr, fv, modc;
	logic modc_d = 1'h0;
	logic edge_pin = 1'h0;
	int fr_cnt = 0;
	int fv_cnt = 0;
	int mod_rise = 0;
	int mod_seen = 0;
	// Directed load: reference divides by 3, main by 4, swallow count 2.
	localparam int EDGES = 12;
	localparam logic [30:0] DIR_LOAD = {14'h0003, 10'h004, 7'h02};
	logic [REF_W-1:0] r_div;
	logic [MAIN_W-1:0] m_div;
	logic [SWAL_W-1:0] a_div;
	logic [31:0] notes[$];
	logic [30:0] cur;
	logic [2:0] bad [3] = '{3'h7, 3'h1, 3'h2};
	int fails = 0;
	int checks_done = 0;

	always #4 sys_clk = ~sys_clk;

	ssl_ctrl_model ctrl_u (.sys_clk(sys_clk), .select_code_bit0(s0), .select_code_bit1(s1),
		.select_code_bit2(s2), .serial_clk(sclk), .serial_data(sdat), .serial_enable(sen),
		.osc_key_line(key));

	ssl_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .select_code_bit0(s0),
		.select_code_bit1(s1), .select_code_bit2(s2), .serial_clk(sclk), .serial_data(sdat),
		.serial_enable(sen), .lock_detect(lock_detect), .osc_key_line(key), .ref_in(edge_pin),
		.prescaler_in(edge_pin), .decoder_match_output_n_reg(match_n), .ref_div_reg(r_div),
		.main_div_reg(m_div), .swal_div_reg(a_div), .loop_bypass_reg(bypass),
		.fault_reg(fault), .fault_led_reg(led), .fault_flag_reg(flag),
		.osc_on_level_reg(osc_on), .modulus_ctrl_reg(modc), .fr_pulse_reg(fr),
		.fv_pulse_reg(fv));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up

	task load_expect(input logic ctl, input logic [30:0] v);
		if (ctl)
			cur = v;
		notes.push_back({cur, 1'h0});
		ctrl_u.load(SELECT_MATCH, {v, ctl});
	endtask : load_expect

	// Same edges on reference and prescaler pins, ten clocks apart.
	task drive_edges;
		repeat (EDGES) begin
			@(negedge sys_clk);
			if (modc === 1'h1)
				mod_seen++;
			@(posedge sys_clk);
			edge_pin <= 1'h1;
			repeat (5) @(posedge sys_clk);
			edge_pin <= 1'h0;
			repeat (4) @(posedge sys_clk);
		end
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : drive_edges

	always @(negedge sys_clk) begin
		if (fr === 1'h1)
			fr_cnt++;
		if (fv === 1'h1)
			fv_cnt++;
		if (modc === 1'h1 && modc_d !== 1'h1)
			mod_rise++;
		modc_d = modc;
	end

	// Every gated enable shows as a bypass rise; the oldest note holds the expected latch.
	always begin
		@(posedge bypass);
		@(negedge sys_clk);
		if (notes.size() == 0) begin
			fails++;
			$display("mismatch at %0t: load taken with no request", $time);
		end else
			check({r_div, m_div, a_div, fault}, notes.pop_front());
		check(32'(match_n), 32'h0);
	end

	initial begin
		#160000;
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		void'($urandom(91));
		cur = {REF_DIV_RESET, MAIN_DIV_RESET, SWAL_DIV_RESET};
		repeat (3) @(posedge sys_clk);
		rstn <= 1'h1;
		@(negedge sys_clk);
		check(32'({r_div, m_div, a_div}), 32'(cur));
		check(32'({match_n, bypass, fault, led, flag, osc_on}), 32'h22);
		repeat (2) load_expect(1'h1, 31'($urandom));
		load_expect(1'h0, 31'($urandom));
		foreach (bad[i])
			ctrl_u.load(bad[i], {31'($urandom), 1'h1});
		check(32'({r_div, m_div, a_div}), 32'(cur));
		ctrl_u.set_key(1'h0);
		repeat (6) @(posedge sys_clk);
		lock_detect <= 1'h0;
		repeat (6) @(posedge sys_clk);
		lock_detect <= 1'h1;
		@(negedge sys_clk);
		check(32'({fault, led, flag, osc_on}), 32'hd);
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		check(32'({fault, led, flag}), 32'h6);
		ctrl_u.set_key(1'h1);
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		check(32'({led, flag, osc_on}), 32'h2);
		ctrl_u.set_key(1'h0);
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		check(32'({led, flag}), 32'h2);
		load_expect(1'h1, DIR_LOAD);
		@(negedge sys_clk);
		check(32'({fault, led, flag}), 32'h1);
		drive_edges();
		check(32'(fr_cnt), 32'(EDGES / 3));
		check(32'(fv_cnt), 32'(EDGES / 4));
		check(32'(mod_rise), 32'(EDGES / 4));
		check(32'(mod_seen), 32'(2 * (EDGES / 4)));
		check(32'(notes.size()), 32'h0);
		wrap_up();
	end
endmodule : ssl_top_tb
